//--- inc/swd_consts.svh
// Field positions and widths of the state-word decoder.
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH
`define SWD_WORD_W        64
`define SWD_BYTE_W        8
`define SWD_NUM_BYTES     5
`define SWD_OUT_LSB       0
`define SWD_NUM_OUTS      8
`define SWD_MON_LSB       12
`define SWD_ALERT_UNMASK  30
`define SWD_TIMEOUT_LSB   31
`define SWD_COND_LSB      35
`define SWD_POLARITY_BIT  39
`define SWD_MONITOR_JUMP_TARGET_LSB   44
`define SWD_ADDR_W        6
`define SWD_NUM_MON       7
`define SWD_RESERVED_MASK 64'h0000_0000_0030_0f00
`endif

//--- inc/swd_pkg.sv
// Types shared by the state-word decoder files.
package swd_pkg;
	typedef enum logic [1:0] {
		SWD_EXIT_NONE    = 2'b00,
		SWD_EXIT_STEP    = 2'b01,
		SWD_EXIT_MONITOR = 2'b10,
		SWD_EXIT_TIMEOUT = 2'b11
	} swd_exit_t;
endpackage

//--- core/swd_mon_channel.sv
// One supply-monitor channel: unmask and exit polarity check.
`timescale 1ns/10ps
module swd_mon_channel (
	// Configuration
	input  wire logic unmask,
	input  wire logic polarity,
	// Monitor input and result
	input  wire logic level,
	output logic      fault
);
	// A masked channel never faults; otherwise fault on the selected level.
	assign fault = unmask & (level == polarity);
endmodule // swd_mon_channel

//--- core/swd_state_word_decode.sv
// State-word decoder of the supply sequencing engine.
// Overview of operation
// - Power outputs hold the state's fixed levels, changing only on state change or a byte write to byte 0.
// - A state is left only by step end, monitor fault or timeout.
// - A monitor fault jumps to the state held in the six-bit jump field.
// - Each state is one 64-bit word, loaded whole on state entry.
// - Bit 13 unmasks supply_monitor_1; bit 12 picks the level that exits.
// - Bit 15 unmasks supply_monitor_2; bit 14 picks the level that exits.
// - Bit 17 unmasks supply_monitor_3; bit 16 picks the level that exits.
// - Bit 19 unmasks high_voltage_monitor; bit 18 picks the exit level.
// - Bit 23 unmasks aux_monitor_1; bit 22 picks the level that exits.
// - Bit 25 unmasks aux_monitor_2; bit 24 picks the level that exits.
// - Bit 27 unmasks aux_monitor_3; bit 26 picks the level that exits.
// - Bit 29 unmasks aux_monitor_4; bit 28 picks the level that exits.
// - A masked channel never causes a fault exit; polarity is then ignored.
// - Bit 30 set: alert_flag high causes a fault exit; no polarity.
// - Timeout code is bits 34 to 31, bit 31 least significant.
// - Condition select is bits 38 to 35, bit 35 least significant.
// - Condition met on high input if bit 39 clear, low if set.
`timescale 1ns/10ps
`include "swd_consts.svh"
module swd_state_word_decode #(
	parameter int NUM_OUTS = `SWD_NUM_OUTS,
	parameter int NUM_COND = 16
) (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// State word load
	input  wire logic                        word_load,
	input  wire logic [`SWD_WORD_W-1:0]      word_in,
	// Byte access to the lower state-word bytes
	input  wire logic                        byte_wr,
	input  wire logic [2:0]                  byte_sel,
	input  wire logic [`SWD_BYTE_W-1:0]      byte_wdata,
	output logic      [`SWD_BYTE_W-1:0]      byte_rdata,
	// Monitor inputs: monitors 1..3, high voltage, aux 1..4
	input  wire logic [`SWD_NUM_MON:0]       monitor_in,
	input  wire logic                        alert_flag,
	input  wire logic [NUM_COND-1:0]         cond_in,
	// Timeout expiry from the delay logic
	input  wire logic                        timeout_expired,
	// Decoded results
	output logic      [NUM_OUTS-1:0]         power_output,
	output logic                             monitor_exit,
	output logic      [3:0]                  timeout_code,
	output logic      [3:0]                  step_condition_select,
	output logic                             step_condition_polarity,
	output logic                             step_done,
	output logic      [`SWD_ADDR_W-1:0]      monitor_jump_target,
	output swd_pkg::swd_exit_t               exit_cause
);
	import swd_pkg::*;

	// ==========================================================
	// Reset synchroniser
	logic rst_meta_ff;
	logic rst_sync_ff;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==========================================================
	// State word storage
	logic [`SWD_WORD_W-1:0] word_ff;
	logic [`SWD_WORD_W-1:0] nxt_word;
	logic [`SWD_WORD_W-1:0] word_clean;

	always_comb begin
		nxt_word = word_ff;
		if (word_load) begin
			nxt_word = word_in;
		end else if (byte_wr && (byte_sel < 3'(`SWD_NUM_BYTES))) begin
			nxt_word[byte_sel*`SWD_BYTE_W +: `SWD_BYTE_W] = byte_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			word_ff <= '0;
		end else begin
			word_ff <= nxt_word;
		end
	end

	assign word_clean = word_ff & ~`SWD_RESERVED_MASK;

	always_comb begin
		byte_rdata = 8'h00;
		if (byte_sel < 3'(`SWD_NUM_BYTES)) begin
			byte_rdata = word_ff[byte_sel*`SWD_BYTE_W +: `SWD_BYTE_W];
		end
	end

	// ==========================================================
	// Field decode
	assign power_output = word_clean[`SWD_OUT_LSB +: NUM_OUTS];
	assign timeout_code = word_clean[`SWD_TIMEOUT_LSB +: 4];
	assign step_condition_select = word_clean[`SWD_COND_LSB +: 4];
	assign step_condition_polarity = word_clean[`SWD_POLARITY_BIT];
	assign monitor_jump_target = word_clean[`SWD_MONITOR_JUMP_TARGET_LSB +: `SWD_ADDR_W];

	// ==========================================================
	// Monitor channels
	logic [`SWD_NUM_MON:0] chan_fault;
	genvar g;
	generate
		for (g = 0; g <= `SWD_NUM_MON; g++) begin : g_mon
			// Pairs sit at 12/13, 14/15, 16/17, 18/19, then skip 20/21.
			localparam int POL = `SWD_MON_LSB + 2*g + ((g >= 4) ? 2 : 0);
			swd_mon_channel swd_mon_channel_inst (
				.unmask   (word_clean[POL+1]),
				.polarity (word_clean[POL]),
				.level    (monitor_in[g]),
				.fault    (chan_fault[g])
			);
		end
	endgenerate

	logic alert_fault;
	assign alert_fault = word_clean[`SWD_ALERT_UNMASK] & alert_flag;
	assign monitor_exit = (|chan_fault) | alert_fault;

	// ==========================================================
	// Step condition
	logic cond_sel_level;
	always_comb begin
		cond_sel_level = 1'b0;
		if (32'(step_condition_select) < NUM_COND) begin
			cond_sel_level = cond_in[step_condition_select];
		end
	end
	assign step_done = cond_sel_level ^ step_condition_polarity;

	// ==========================================================
	// Exit cause, registered; monitor fault has priority
	swd_exit_t exit_ff;
	swd_exit_t nxt_exit;
	always_comb begin
		case ({monitor_exit, timeout_expired, step_done})
			3'b100, 3'b101, 3'b110, 3'b111: nxt_exit = SWD_EXIT_MONITOR;
			3'b010, 3'b011:                 nxt_exit = SWD_EXIT_TIMEOUT;
			3'b001:                         nxt_exit = SWD_EXIT_STEP;
			default:                        nxt_exit = SWD_EXIT_NONE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			exit_ff <= SWD_EXIT_NONE;
		end else begin
			exit_ff <= nxt_exit;
		end
	end
	assign exit_cause = exit_ff;

endmodule // swd_state_word_decode

//--- verif/swd_chk.sv
// Assertion checker of the state-word decoder.
`timescale 1ns/10ps
module swd_chk #(parameter int NUM_OUTS = 8) (
	// Load side
	input logic ref_clk,
	input logic nrst,
	input logic word_load,
	input logic [63:0] word_in,
	input logic byte_wr,
	input logic timeout_expired,
	// Decoded results
	input logic [NUM_OUTS-1:0] power_output,
	input logic monitor_exit,
	input logic [3:0] timeout_code,
	input logic [3:0] step_condition_select,
	input logic step_condition_polarity,
	input logic step_done,
	input logic [5:0] monitor_jump_target,
	input swd_pkg::swd_exit_t exit_cause
);
	import swd_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_load; word_load; endsequence
	sequence s_idle; !word_load && !byte_wr; endsequence
	a_out_load: assert property (s_load |=> power_output == $past(word_in[7:0]))
		else $error("outputs not loaded");
	a_out_hold: assert property (s_idle |=> $stable(power_output))
		else $error("outputs moved");
	a_tmo_load: assert property (s_load |=> timeout_code == $past(word_in[34:31]))
		else $error("timeout code");
	a_ctl_hold: assert property (s_idle |=> $stable(timeout_code))
		else $error("timeout code moved");
	a_cond_load: assert property (s_load |=>
		{step_condition_polarity, step_condition_select} == $past(word_in[39:35]))
		else $error("condition fields");
	a_jump_load: assert property (s_load |=> monitor_jump_target == $past(word_in[49:44]))
		else $error("jump target");
	a_fault_exit: assert property (monitor_exit && $past(nrst) && $past(nrst, 2) |=>
		exit_cause == SWD_EXIT_MONITOR) else $error("fault exit lost");
	a_exit_src: assert property (exit_cause == SWD_EXIT_MONITOR && $past(nrst) &&
		$past(nrst, 2) |-> $past(monitor_exit)) else $error("fault exit without cause");
	a_tmo_exit: assert property (!monitor_exit && timeout_expired && $past(nrst) &&
		$past(nrst, 2) |=> exit_cause == SWD_EXIT_TIMEOUT) else $error("timeout exit lost");
	a_step_exit: assert property (!monitor_exit && !timeout_expired && step_done &&
		$past(nrst) && $past(nrst, 2) |=> exit_cause == SWD_EXIT_STEP)
		else $error("step exit lost");
	a_none_exit: assert property (!monitor_exit && !timeout_expired && !step_done &&
		$past(nrst) && $past(nrst, 2) |=> exit_cause == SWD_EXIT_NONE)
		else $error("exit without cause");
endmodule // swd_chk
bind swd_state_word_decode swd_chk #(.NUM_OUTS(NUM_OUTS)) swd_chk_inst (.ref_clk, .nrst,
	.word_load, .word_in, .byte_wr, .timeout_expired, .power_output, .monitor_exit,
	.timeout_code, .step_condition_select, .step_condition_polarity, .step_done,
	.monitor_jump_target, .exit_cause);

//--- verif/swd_mon_model.sv
// Model of the supply monitor comparators.
`timescale 1ns/10ps
module swd_mon_model (
	// Clock and requested levels
	input logic ref_clk,
	input logic [8:0] lvl_req,
	// Comparator outputs
	output logic [7:0] monitor_in = 8'h00,
	output logic alert_flag = 1'b0
);
	always @(posedge ref_clk) {alert_flag, monitor_in} <= lvl_req;
endmodule // swd_mon_model

//--- verif/swd_tb_top.sv
// Randomised bench of the state-word decoder.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t %h %h", $time, a, b); end end
module sequencer_state_word_decode_tb_top;
	import swd_pkg::*;
	logic ref_clk = '0, nrst = '0, word_load = '0, byte_wr = '0, timeout_expired = '0;
	logic [63:0] word_in = '0, sh = '0, w;
	logic [8:0] lvl_req = '0;
	logic [15:0] cond_in = '0;
	logic [7:0] byte_wdata = '0, byte_rdata, power_output, monitor_in;
	logic [2:0] byte_sel = '0;
	logic [5:0] monitor_jump_target;
	logic [3:0] timeout_code, step_condition_select;
	logic alert_flag, monitor_exit, step_condition_polarity, step_done;
	swd_exit_t exit_cause;
	int bad_count = 0, checks_done = 0, seed = 32'h6d6d, r;
	always #4 ref_clk = ~ref_clk;
	swd_mon_model swd_mon_model_inst (.ref_clk, .lvl_req, .monitor_in, .alert_flag);
	swd_state_word_decode swd_state_word_decode_inst (.ref_clk, .nrst, .word_load, .word_in,
		.byte_wr, .byte_sel, .byte_wdata, .byte_rdata, .monitor_in, .alert_flag, .cond_in,
		.timeout_expired, .power_output, .monitor_exit, .timeout_code, .step_condition_select,
		.step_condition_polarity, .step_done, .monitor_jump_target, .exit_cause);
	function automatic logic mexp(logic [63:0] v, logic [8:0] m);
		mexp = v[30] & m[8];
		for (int k = 0; k < 8; k++)
			mexp |= v[2*k+13+2*(k/4)] & (m[k] == v[2*k+12+2*(k/4)]);
	endfunction
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 500; i++) begin
			if (i == 250) begin
				@(posedge ref_clk);
				nrst <= 1'b0;
				word_load <= 1'b0;
				byte_wr <= 1'b0;
				@(posedge ref_clk);
				#1;
				`CHK({power_output, monitor_jump_target, timeout_code, exit_cause}, 20'h0)
				`CHK({step_condition_select, step_condition_polarity}, 5'h00)
				@(posedge ref_clk);
				nrst <= 1'b1;
				repeat (3) @(posedge ref_clk);
				sh = '0;
			end
			@(posedge ref_clk);
			r = $random(seed);
			w = i ? {$random(seed), $random(seed)} : 64'h1575_5f00;
			word_load <= !i || r[0];
			word_in <= w;
			byte_wr <= r[1];
			byte_sel <= r[4:2];
			byte_wdata <= r[12:5];
			lvl_req <= i ? r[21:13] : 9'h0ff;
			timeout_expired <= r[22];
			cond_in <= r[31:16];
			if (!i || r[0]) sh = w;
			else if (r[1] && r[4:2] < 5) sh[r[4:2]*8+:8] = r[12:5];
			@(posedge ref_clk);
			#1;
			`CHK(power_output, sh[7:0])
			`CHK({timeout_code, step_condition_select}, {sh[34:31], sh[38:35]})
			`CHK(monitor_jump_target, sh[49:44])
			`CHK(step_done, cond_in[sh[38:35]] ^ sh[39])
			`CHK(monitor_exit, mexp(sh, lvl_req))
			`CHK(byte_rdata, (r[4:2] < 5) ? sh[r[4:2]*8+:8] : 8'h00)
		end
		wrap_up();
	end
endmodule // sequencer_state_word_decode_tb_top
